/* File: shared/svlf_map.svh */
// Purpose: Constants for the serial video link framer with self test
// Assumes: Included by its bare name; definitions only
// Notes: Field positions refer to the forward symbol and the back-channel frame
// Summary of operation
// - One 35-bit symbol per clock: embedded clock, controls, RGB, audio.
// - Forward payload is scrambled, randomized and DC-balanced before sending.
// - Range select one means 5-15 MHz pixel clock, zero means 15-85 MHz.
// - Receive back channel frames carrying I2C, CRC and four GPIO bits.
// - Back channel runs concurrently with forward channel, full duplex.
// - Control channel bridges I2C both ways, yielding to other local masters.
// - Display mode: local host I2C bytes are forwarded to the far end.
// - Camera mode: far-end I2C bytes are replayed on the local bus.
// - With filter on, HS and DE changes need three clocks, else one.
// - Self test starts at far end and arrives via back-channel indication.
// - Self-test clock choice comes from far end: pixel clock or oscillator.
// - Self-test indication wakes the device and sends scrambled all-zeros.
// - During self test every back-channel frame CRC is checked, errors kept.
// - Test length follows far-end enable pulse, then normal video resumes.
// - In self test video inputs are ignored, all-zeros sent instead.
// - Back-channel CRC errors counted in eight bits, cleared on test entry.
`ifndef SVLF_MAP_SVH
`define SVLF_MAP_SVH

`define SVLF_SYM_W        35
`define SVLF_PAY_W        32
`define SVLF_SYM_CLK_HI   34
`define SVLF_SYM_CLK_LO   33
`define SVLF_SYM_INV      32
`define SVLF_BC_DATA_W    16
`define SVLF_BC_CRC_W     4
`define SVLF_BC_FRAME_W   20
`define SVLF_BC_GPIO_LSB  0
`define SVLF_BC_TEST_BIT  4
`define SVLF_BC_OSC_BIT   5
`define SVLF_BC_I2C_VLD   7
`define SVLF_BC_I2C_LSB   8
`define SVLF_CRC_POLY     4'h3
`define SVLF_CRC_INIT     4'hf
`define SVLF_LFSR_POLY    32'h80200003
`define SVLF_LFSR_SEED    32'h0000_0001
`define SVLF_FILT_CLKS    3
`define SVLF_I2C_SHIFT_W  9
`define SVLF_LF_MIN_MHZ   5
`define SVLF_LF_MAX_MHZ   15
`define SVLF_HF_MAX_MHZ   85

`endif

/* File: shared/svlf_pkg.sv */
// Purpose: Types for the serial video link framer
// Assumes: Constants come from svlf_map.svh
// Notes: Each core module keeps all its state in one of these structs
`include "svlf_map.svh"
package svlf_pkg;

  typedef enum logic {SVLF_NORMAL, SVLF_SELFTEST} svlf_mode_t;

  typedef struct packed {
    logic [31:0] lfsr;
    logic signed [7:0] disp;
    logic [`SVLF_SYM_W-1:0] sym;
  } svlf_scr_t;

  typedef struct packed {
    logic [4:0]  cnt;
    logic [`SVLF_BC_FRAME_W-1:0] shift;
    logic [`SVLF_BC_DATA_W-1:0]  word;
    logic        err;
    logic        tog;
    logic [1:0]  rst_sync;
  } svlf_bcrx_t;

  typedef struct packed {
    logic [30:0] vid1;
    logic [30:0] vid2;
    logic [3:0]  cfg1;
    logic [3:0]  cfg2;
    logic [2:0]  tog_sync;
    logic [1:0]  ctl;
    logic [1:0][1:0] run;
    svlf_mode_t  mode;
    logic [7:0]  crc_errs;
    logic        osc_sel;
    logic        link_det;
    logic [3:0]  gpio;
    logic [8:0]  i2c_sh;
    logic [3:0]  i2c_cnt;
    logic        i2c_rdy;
    logic [7:0]  rep_data;
    logic        rep_pend;
    logic        rep_vld;
    logic        awake;
    logic        low_rng;
  } svlf_top_t;

endpackage : svlf_pkg

/* File: core/svlf_scrambler.sv */
// Purpose: Scramble and DC-balance a payload into a 35-bit symbol
// Assumes: One payload word per clock
// Notes: LFSR is never reset outside reset, so mode changes keep lock
`timescale 1ns/1ps
`include "svlf_map.svh"
module svlf_scrambler
(
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  input  wire logic [`SVLF_PAY_W-1:0] payload_in,
  output logic      [`SVLF_SYM_W-1:0] sym_out
);

  svlf_pkg::svlf_scr_t st_q;
  svlf_pkg::svlf_scr_t st_d;

  function automatic logic [31:0] lfsr_adv(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int i = 0; i < `SVLF_PAY_W; i++)
    begin
      r = r[0] ? ((r >> 1) ^ `SVLF_LFSR_POLY) : (r >> 1);
    end
    return r;
  endfunction : lfsr_adv

  function automatic logic signed [7:0] weight(input logic [31:0] w);
    logic [7:0] ones;
    ones = 8'h00;
    for (int i = 0; i < 32; i++)
    begin
      ones = ones + {7'h00, w[i]};
    end
    return $signed({ones[6:0], 1'b0}) - 8'sd32;
  endfunction : weight

  always_comb
  begin
    logic [31:0] scr;
    logic signed [7:0] w;
    logic inv;
    st_d = st_q;
    scr  = payload_in ^ st_q.lfsr;
    w    = weight(scr);
    inv  = (st_q.disp >= 0) ? (w > 0) : (w < 0);
    if (inv)
    begin
      scr = ~scr;
      w   = -w;
    end
    st_d.disp = st_q.disp + w + (inv ? 8'sd1 : -8'sd1);
    st_d.lfsr = lfsr_adv(st_q.lfsr);
    st_d.sym  = {1'b1, 1'b0, inv, scr};
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_q.lfsr <= `SVLF_LFSR_SEED;
      st_q.disp <= 8'sh00;
      st_q.sym  <= 35'h400000000;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sym_out = st_q.sym;

endmodule : svlf_scrambler

/* File: core/svlf_bc_rx.sv */
// Purpose: Receive back-channel frames on the link clock
// Assumes: Link clock runs during reset; frame high over a whole frame
// Notes: Word and error stay stable until the next toggle
`timescale 1ns/1ps
`include "svlf_map.svh"
module svlf_bc_rx
(
  input  wire logic                      link_clk_in,
  input  wire logic                      resetn_in,
  input  wire logic                      bc_frame_in,
  input  wire logic                      bc_valid_in,
  input  wire logic                      bc_bit_in,
  output logic      [`SVLF_BC_DATA_W-1:0] word_out,
  output logic                           crc_err_out,
  output logic                           toggle_out
);

  svlf_pkg::svlf_bcrx_t st_q;
  svlf_pkg::svlf_bcrx_t st_d;

  function automatic logic [3:0] crc4(input logic [15:0] d);
    logic [3:0] c;
    c = `SVLF_CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      c = (c[3] ^ d[i]) ? ({c[2:0], 1'b0} ^ `SVLF_CRC_POLY) : {c[2:0], 1'b0};
    end
    return c;
  endfunction : crc4

  always_comb
  begin
    logic [`SVLF_BC_FRAME_W-1:0] sh;
    st_d          = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], resetn_in};
    sh            = {st_q.shift[`SVLF_BC_FRAME_W-2:0], bc_bit_in};
    if (!bc_frame_in)
    begin
      st_d.cnt = 5'h00;
    end
    else if (bc_valid_in)
    begin
      st_d.shift = sh;
      if (st_q.cnt == 5'(`SVLF_BC_FRAME_W - 1))
      begin
        st_d.cnt  = 5'h00;
        st_d.word = sh[`SVLF_BC_FRAME_W-1:`SVLF_BC_CRC_W];
        st_d.err  = crc4(sh[`SVLF_BC_FRAME_W-1:`SVLF_BC_CRC_W]) != sh[3:0];
        st_d.tog  = ~st_q.tog;
      end
      else
      begin
        st_d.cnt = st_q.cnt + 5'h01;
      end
    end
  end

  // Local reset from a two-stage copy of the system reset
  always_ff @(posedge link_clk_in)
  begin
    if (!st_q.rst_sync[1])
    begin
      st_q.cnt      <= 5'h00;
      st_q.shift    <= 20'h00000;
      st_q.word     <= 16'h0000;
      st_q.err      <= 1'b0;
      st_q.tog      <= 1'b0;
      st_q.rst_sync <= st_d.rst_sync;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign word_out    = st_q.word;
  assign crc_err_out = st_q.err;
  assign toggle_out  = st_q.tog;

endmodule : svlf_bc_rx

/* File: core/svlf_framer.sv */
// Purpose: Link layer of the serializer: framing, control filter, back channel, self test
// Assumes: clk_in is the symbol clock; video and config pins are synchronised here
// Notes: Clock source choice in self test is applied outside, from selftest_osc_select_out
`timescale 1ns/1ps
`include "svlf_map.svh"
module svlf_framer
(
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        link_clk_in,
  input  wire logic        bc_frame_in,
  input  wire logic        bc_valid_in,
  input  wire logic        bc_bit_in,
  input  wire logic        low_freq_range_select_in,
  input  wire logic        filter_enable_in,
  input  wire logic        camera_mode_in,
  input  wire logic        powerdown_in,
  input  wire logic        vertical_sync_in,
  input  wire logic        horizontal_sync_in,
  input  wire logic        data_enable_in,
  input  wire logic [23:0] rgb_in,
  input  wire logic [3:0]  audio_in,
  input  wire logic [7:0]  i2c_fwd_data_in,
  input  wire logic        i2c_fwd_valid_in,
  input  wire logic        i2c_local_busy_in,
  input  wire logic        i2c_replay_ack_in,
  output logic      [34:0] sym_out,
  output logic             i2c_fwd_ready_out,
  output logic      [7:0]  i2c_replay_data_out,
  output logic             i2c_replay_valid_out,
  output logic      [3:0]  gpio_out,
  output logic             selftest_active_out,
  output logic             selftest_osc_select_out,
  output logic             awake_out,
  output logic             link_detect_out,
  output logic      [7:0]  crc_err_count_out,
  output logic             low_range_out
);

  localparam int FILT_CLKS = `SVLF_FILT_CLKS;

  svlf_pkg::svlf_top_t st_q;
  svlf_pkg::svlf_top_t st_d;

  logic [`SVLF_BC_DATA_W-1:0] bc_word;
  logic                       bc_err;
  logic                       bc_tog;
  logic [`SVLF_PAY_W-1:0]     payload;

  // Back channel lives on the link clock; only a toggle, a held word and its error flag cross
  svlf_bc_rx u_bc_rx
  (
    .link_clk_in (link_clk_in),
    .resetn_in   (resetn_in),
    .bc_frame_in (bc_frame_in),
    .bc_valid_in (bc_valid_in),
    .bc_bit_in   (bc_bit_in),
    .word_out    (bc_word),
    .crc_err_out (bc_err),
    .toggle_out  (bc_tog)
  );

  svlf_scrambler u_scr
  (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .payload_in (payload),
    .sym_out    (sym_out)
  );

  always_comb
  begin
    logic        vs;
    logic [1:0]  raw;
    logic [23:0] rgb;
    logic [3:0]  aud;
    logic        f_en;
    logic        cam;
    logic        pd;
    logic        lf;
    logic        frame_new;
    logic        test_req;
    logic        i2c_bit;
    st_d = st_q;

    // Two stages on every video and config pin before any logic looks at it
    st_d.vid1 = {vertical_sync_in, horizontal_sync_in, data_enable_in, rgb_in, audio_in};
    st_d.vid2 = st_q.vid1;
    st_d.cfg1 = {low_freq_range_select_in, filter_enable_in, camera_mode_in, powerdown_in};
    st_d.cfg2 = st_q.cfg1;
    {vs, raw, rgb, aud} = st_q.vid2;
    {lf, f_en, cam, pd} = st_q.cfg2;

    // PLL range follows the select; the rate bands are the source's duty
    st_d.low_rng = lf;

    // Toggle crossing: stage two against stage three marks a new frame
    st_d.tog_sync = {st_q.tog_sync[1:0], bc_tog};
    frame_new     = st_q.tog_sync[2] ^ st_q.tog_sync[1];
    test_req      = bc_word[`SVLF_BC_TEST_BIT];

    // Filter rejects HS and DE pulses shorter than the minimum
    for (int i = 0; i < 2; i++)
    begin
      if (raw[i] == st_q.ctl[i])
      begin
        st_d.run[i] = 2'h0;
      end
      else if (!f_en || (int'(st_q.run[i]) + 1 >= FILT_CLKS))
      begin
        st_d.ctl[i] = raw[i];
        st_d.run[i] = 2'h0;
      end
      else
      begin
        st_d.run[i] = st_q.run[i] + 2'h1;
      end
    end

    if (frame_new)
    begin
      if (!bc_err)
      begin
        st_d.link_det = 1'b1;
        st_d.gpio     = bc_word[`SVLF_BC_GPIO_LSB +: 4];
      end
      // Counts only once locked; saturates rather than wrapping
      if (bc_err && st_q.link_det && st_q.crc_errs != 8'hff)
      begin
        st_d.crc_errs = st_q.crc_errs + 8'h01;
      end
    end

    case (st_q.mode)
      svlf_pkg::SVLF_NORMAL:
      begin
        if (frame_new && !bc_err && test_req)
        begin
          st_d.mode     = svlf_pkg::SVLF_SELFTEST;
          st_d.crc_errs = 8'h00;
          st_d.osc_sel  = bc_word[`SVLF_BC_OSC_BIT];
        end
      end
      svlf_pkg::SVLF_SELFTEST:
      begin
        if (frame_new && bc_err)
        begin
          st_d.crc_errs = (st_q.crc_errs == 8'hff) ? 8'hff : st_q.crc_errs + 8'h01;
        end
        // Scrambler keeps running, so leaving costs no lock
        if (frame_new && !bc_err && !test_req)
        begin
          st_d.mode = svlf_pkg::SVLF_NORMAL;
        end
      end
      default:
      begin
        st_d.mode = svlf_pkg::SVLF_NORMAL;
      end
    endcase

    st_d.awake = !pd || (st_d.mode == svlf_pkg::SVLF_SELFTEST);

    // Display mode: local host bytes go out one bit per symbol
    i2c_bit = st_q.i2c_sh[8];
    if (st_q.i2c_cnt != 4'h0)
    begin
      st_d.i2c_sh  = {st_q.i2c_sh[7:0], 1'b0};
      st_d.i2c_cnt = st_q.i2c_cnt - 4'h1;
    end
    else if (st_q.i2c_rdy && i2c_fwd_valid_in)
    begin
      st_d.i2c_sh  = {1'b1, i2c_fwd_data_in};
      st_d.i2c_cnt = 4'(`SVLF_I2C_SHIFT_W);
    end
    st_d.i2c_rdy = !cam && st_d.i2c_cnt == 4'h0 && st_d.mode == svlf_pkg::SVLF_NORMAL
                   && !(st_q.i2c_rdy && i2c_fwd_valid_in);

    // Camera mode: far-end bytes wait until the local bus is free
    if (st_q.rep_vld && i2c_replay_ack_in)
    begin
      st_d.rep_vld = 1'b0;
    end
    // Byte on offer must not change under the local master, so later ones drop
    if (frame_new && !bc_err && cam && bc_word[`SVLF_BC_I2C_VLD] && !st_q.rep_pend
        && !st_q.rep_vld)
    begin
      st_d.rep_data = bc_word[`SVLF_BC_I2C_LSB +: 8];
      st_d.rep_pend = 1'b1;
    end
    if (st_q.rep_pend && !st_q.rep_vld && !i2c_local_busy_in)
    begin
      st_d.rep_vld  = 1'b1;
      st_d.rep_pend = 1'b0;
    end

    // Self test and sleep send zeros; the scrambler still randomises them
    if (st_q.mode == svlf_pkg::SVLF_SELFTEST || !st_q.awake)
    begin
      payload = '0;
    end
    else
    begin
      payload = {vs, st_q.ctl, rgb, aud, i2c_bit};
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      st_q <= '0;
      st_q.mode <= svlf_pkg::SVLF_NORMAL;
      st_q.awake <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign i2c_fwd_ready_out       = st_q.i2c_rdy;
  assign i2c_replay_data_out     = st_q.rep_data;
  assign i2c_replay_valid_out    = st_q.rep_vld;
  assign gpio_out                = st_q.gpio;
  assign selftest_active_out     = st_q.mode == svlf_pkg::SVLF_SELFTEST;
  assign selftest_osc_select_out = st_q.osc_sel;
  assign awake_out               = st_q.awake;
  assign link_detect_out         = st_q.link_det;
  assign crc_err_count_out       = st_q.crc_errs;
  assign low_range_out           = st_q.low_rng;

endmodule : svlf_framer

/* File: test/svlf_chk.sv */
// Purpose: Port checks for the link framer
// Assumes: Bound to svlf_framer, clk_in domain only
// Notes: Link-side inputs are judged by the bench
`timescale 1ns/1ps
module svlf_chk
(
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        low_freq_range_select_in,
  input wire logic        i2c_fwd_valid_in,
  input wire logic        i2c_replay_ack_in,
  input wire logic [34:0] sym_out,
  input wire logic        i2c_fwd_ready_out,
  input wire logic [7:0]  i2c_replay_data_out,
  input wire logic        i2c_replay_valid_out,
  input wire logic        selftest_active_out,
  input wire logic        awake_out,
  input wire logic        link_detect_out,
  input wire logic [7:0]  crc_err_count_out,
  input wire logic        low_range_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  property p_sym_clk;
    sym_out[34:33] == 2'b10;
  endproperty
  a_sym_clk: assert property (p_sym_clk) else $error("clock bits wrong");
  property p_scramble;
    selftest_active_out && $past(selftest_active_out) |-> sym_out[31:0] != $past(sym_out[31:0]);
  endproperty
  a_scramble: assert property (p_scramble) else $error("pattern not scrambled");
  property p_wake;
    selftest_active_out |-> awake_out;
  endproperty
  a_wake: assert property (p_wake) else $error("asleep in self test");
  property p_range;
    $stable(low_freq_range_select_in) [*6] |-> low_range_out == low_freq_range_select_in;
  endproperty
  a_range: assert property (p_range) else $error("range copy wrong");
  property p_cnt_step;
    $changed(crc_err_count_out) |->
      crc_err_count_out == $past(crc_err_count_out) + 8'h01 || crc_err_count_out == 8'h00;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count jumped");
  property p_cnt_clr;
    $rose(selftest_active_out) |-> ##[0:1] crc_err_count_out == 8'h00;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("count not cleared");
  property p_fwd_gap;
    i2c_fwd_valid_in && i2c_fwd_ready_out |=>
      !i2c_fwd_ready_out [*8] ##1 !i2c_fwd_ready_out ##[1:4] i2c_fwd_ready_out;
  endproperty
  a_fwd_gap: assert property (p_fwd_gap) else $error("forward slot wrong");
  property p_fwd_test;
    selftest_active_out && $past(selftest_active_out) |-> !i2c_fwd_ready_out;
  endproperty
  a_fwd_test: assert property (p_fwd_test) else $error("forward in self test");
  property p_rep_hold;
    i2c_replay_valid_out && !i2c_replay_ack_in |=>
      i2c_replay_valid_out && $stable(i2c_replay_data_out);
  endproperty
  a_rep_hold: assert property (p_rep_hold) else $error("replay dropped");
  property p_link;
    link_detect_out |=> link_detect_out;
  endproperty
  a_link: assert property (p_link) else $error("link detect lost");
  c_test: cover property ($rose(selftest_active_out));
  c_fwd: cover property (i2c_fwd_valid_in && i2c_fwd_ready_out);
  c_rep: cover property (i2c_replay_valid_out && i2c_replay_ack_in);
  c_err: cover property ($changed(crc_err_count_out));
endmodule : svlf_chk
bind svlf_framer svlf_chk u_chk (.clk_in, .resetn_in, .low_freq_range_select_in,
  .i2c_fwd_valid_in, .i2c_replay_ack_in, .sym_out, .i2c_fwd_ready_out, .i2c_replay_data_out,
  .i2c_replay_valid_out, .selftest_active_out, .awake_out, .link_detect_out,
  .crc_err_count_out, .low_range_out);

/* File: test/svlf_far.sv */
// Purpose: Far-end deserializer model: back-channel frames and pass flag
// Assumes: Link clock stands still between frames
// Notes: Pass flag only checks the embedded clock bits
`timescale 1ns/1ps
module svlf_far
(
  input  wire logic        clk_in,
  input  wire logic [34:0] sym_in,
  output logic             link_clk_out,
  output logic             bc_frame_out,
  output logic             bc_valid_out,
  output logic             bc_bit_out,
  output logic             pass_out
);
  logic testing_q;
  initial
  begin
    link_clk_out = 1'b0;
    bc_frame_out = 1'b0;
    bc_valid_out = 1'b0;
    bc_bit_out   = 1'b0;
    pass_out     = 1'b0;
    testing_q    = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n)
    begin
      #16 link_clk_out = 1'b1;
      #16 link_clk_out = 1'b0;
    end
  endtask : tick
  // Bad frames corrupt the check field only
  task automatic send(input logic [15:0] data, input logic bad);
    logic [3:0]  crc;
    logic [19:0] fr;
    crc = 4'hf;
    for (int i = 15; i >= 0; i--)
      crc = {crc[2:0], 1'b0} ^ ((crc[3] ^ data[i]) ? 4'h3 : 4'h0);
    fr = {data, crc ^ {3'h0, bad}};
    bc_frame_out = 1'b1;
    bc_valid_out = 1'b1;
    for (int i = 19; i >= 0; i--)
    begin
      bc_bit_out = fr[i];
      tick(1);
    end
    bc_frame_out = 1'b0;
    bc_valid_out = 1'b0;
    bc_bit_out = ~bc_bit_out;
    if (!bad && data[4] && !testing_q)
      pass_out = 1'b1;
    if (!bad)
      testing_q = data[4];
  endtask : send
  // Pass stays low after any error until the next test
  always @(posedge clk_in)
    if (testing_q && sym_in[34:33] !== 2'b10)
      pass_out <= 1'b0;
endmodule : svlf_far

/* File: test/svlf_framer_test.sv */
// Purpose: Directed bench for the link framer
// Assumes: Far model makes the link clock
// Notes: Frame effects checked a fixed margin after each frame
`timescale 1ns/1ps
`include "svlf_map.svh"
module svlf_framer_test;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic lfrs = 1'b0, cam = 1'b0, pdn = 1'b0, vs = 1'b0, hs = 1'b0, de = 1'b0;
  logic [23:0] rgb = 24'h000000;
  logic [7:0] fdata = 8'h00;
  logic fvalid = 1'b0, busy = 1'b0, ack = 1'b0;
  logic lclk, bframe, bvalid, bbit, pass;
  logic [34:0] sym;
  logic [7:0] rdata, cnt;
  logic [3:0] gpio;
  logic fready, rvalid, active, osc, awake, link, lowr;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  always #4 clk_in = ~clk_in;
  // Slow controls keep the source spacing limits
  always @(posedge clk_in)
  begin
    rgb <= rgb + 24'h000001;
    if (rgb[6:0] == 7'h00) hs <= ~hs;
    if (rgb[6:0] == 7'h40) de <= ~de;
    if (rgb[7:0] == 8'h00) vs <= ~vs;
  end
  svlf_framer DUT (.clk_in(clk_in), .resetn_in(resetn_in), .link_clk_in(lclk),
    .bc_frame_in(bframe), .bc_valid_in(bvalid), .bc_bit_in(bbit),
    .low_freq_range_select_in(lfrs), .filter_enable_in(1'b1), .camera_mode_in(cam),
    .powerdown_in(pdn), .vertical_sync_in(vs), .horizontal_sync_in(hs),
    .data_enable_in(de), .rgb_in(rgb), .audio_in(rgb[7:4]), .i2c_fwd_data_in(fdata),
    .i2c_fwd_valid_in(fvalid), .i2c_local_busy_in(busy), .i2c_replay_ack_in(ack),
    .sym_out(sym), .i2c_fwd_ready_out(fready), .i2c_replay_data_out(rdata),
    .i2c_replay_valid_out(rvalid), .gpio_out(gpio), .selftest_active_out(active),
    .selftest_osc_select_out(osc), .awake_out(awake), .link_detect_out(link),
    .crc_err_count_out(cnt), .low_range_out(lowr));
  svlf_far far (.clk_in(clk_in), .sym_in(sym), .link_clk_out(lclk), .bc_frame_out(bframe),
    .bc_valid_out(bvalid), .bc_bit_out(bbit), .pass_out(pass));
  task automatic chk(input logic [34:0] got, input logic [34:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic clks(input int k);
    repeat (k) @(posedge clk_in);
  endtask : clks
  task automatic frame(input logic [15:0] d, input logic bad);
    far.send(d, bad);
    clks(12);
  endtask : frame
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic wait_hi(ref logic s, input string what);
    // Sampled at the falling edge, where outputs have settled
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_in);
      if (s === 1'b1)
        break;
    end
    if (n == 40)
    begin
      chk(0, 1, what);
      test_done;
    end
  endtask : wait_hi
  initial
  begin
    fork
      far.tick(3);
      clks(8);
    join
    chk(sym, 35'h400000000, "reset symbol");
    chk(awake, 1'b1, "reset awake");
    @(posedge clk_in) resetn_in <= 1'b1;
    // Link side leaves reset only on its own edges
    far.tick(3);
    frame(16'h000a, 1'b0);
    chk(gpio, 4'ha, "gpio");
    chk(link, 1'b1, "link detect");
    frame(16'h0005, 1'b1);
    chk(gpio, 4'ha, "gpio kept");
    chk(cnt, 8'h01, "crc count");
    @(posedge clk_in) lfrs <= 1'b1;
    clks(6);
    chk(lowr, 1'b1, "range");
    $display("test status_and_range done");
    @(posedge clk_in)
    begin
      fdata <= 8'ha5;
      fvalid <= 1'b1;
    end
    wait_hi(fready, "fwd ready");
    @(posedge clk_in) fvalid <= 1'b0;
    for (n = 0; n < 30; n++)
    begin
      @(negedge clk_in);
      if (fready === 1'b1)
        break;
    end
    chk(35'(n), 35'(`SVLF_I2C_SHIFT_W), "fwd slot");
    $display("test forward done");
    @(posedge clk_in)
    begin
      cam <= 1'b1;
      busy <= 1'b1;
    end
    clks(4);
    frame(16'h3c8a, 1'b0);
    chk(rvalid, 1'b0, "replay while busy");
    @(posedge clk_in) busy <= 1'b0;
    wait_hi(rvalid, "replay valid");
    chk(rdata, 8'h3c, "replay data");
    @(posedge clk_in) ack <= 1'b1;
    @(posedge clk_in) ack <= 1'b0;
    clks(2);
    chk(rvalid, 1'b0, "replay taken");
    $display("test replay done");
    @(posedge clk_in) pdn <= 1'b1;
    clks(6);
    chk(awake, 1'b0, "asleep");
    frame(16'h003a, 1'b0);
    chk(active, 1'b1, "enter test");
    chk(osc, 1'b1, "osc select");
    chk(awake, 1'b1, "woken");
    chk(cnt, 8'h00, "count cleared");
    chk(pass, 1'b1, "far pass");
    frame(16'h000a, 1'b1);
    chk(active, 1'b1, "bad frame kept mode");
    chk(cnt, 8'h01, "test crc count");
    frame(16'h000a, 1'b0);
    chk(active, 1'b0, "leave test");
    chk(cnt, 8'h01, "count record");
    chk(pass, 1'b1, "pass held");
    $display("test selftest done");
    test_done;
  end
endmodule : svlf_framer_test
